// file: hw/tol_ctrl.v
// Turn-on limit fault response, soft-off sequencer and fault summary byte
`timescale 1ns/1ns
`default_nettype none
`include "tol_map.vh"
module tol_ctrl #(
   parameter [31:0] QMS_CYC = `TOL_QMS_NS / `TOL_CLK_NS
) (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire        cmd_valid,
   input  wire        cmd_write,
   input  wire [7:0]  cmd_code,
   input  wire [15:0] cmd_wdata,
   output reg         cmd_ack_q,
   output reg  [15:0] cmd_rdata_q,
   input  wire        on_request,
   input  wire        limit_expired,
   input  wire        vout_valid,
   input  wire [15:0] vout_sample,
   input  wire [15:0] target_output_voltage,
   input  wire [6:0]  start_ramp_time,
   input  wire        busy_event,
   input  wire        clear_faults,
   input  wire        output_overvoltage_fault_flag,
   input  wire        output_overcurrent_summary,
   input  wire        input_undervoltage_summary,
   input  wire        temperature_summary,
   input  wire        comm_memory_logic_summary,
   output reg         convert_en_q,
   output reg         soft_off_ramp_q,
   output reg         turn_on_limit_flag_q,
   output reg         vout_summary_q,
   output reg         smb_alert_n_q
);

   localparam [31:0] INT_CYC = `TOL_INT_DLY_NS / `TOL_CLK_NS;
   localparam [3:0] S_IDLE  = 4'h0;
   localparam [3:0] S_START = 4'h1;
   localparam [3:0] S_RUN   = 4'h2;
   localparam [3:0] S_FWAIT = 4'h3;
   localparam [3:0] S_HICC  = 4'h4;
   localparam [3:0] S_LATCH = 4'h5;
   localparam [3:0] S_OWAIT = 4'h6;
   localparam [3:0] S_ORAMP = 4'h7;

   ////////////////////////////////////////////////////////////////////////////
   // Linear value to quarter-ms count; exponent below -2 gives all ones
   function [19:0] to_quarters;
      input [15:0] v;
      reg   [4:0]  e;
      begin
         e = v[15:11];
         if (v[10:0] == 11'h000)
            to_quarters = 20'h00000;
         else if (v[10] || (e[4] && e < `TOL_EXP_MIN))
            to_quarters = 20'hFFFFF;
         else if (e[4])
            to_quarters = {9'h000, v[10:0]} << (e - `TOL_EXP_MIN);
         // Larger shifts would wrap the 20-bit count back into range
         else if (e > 5'h08)
            to_quarters = 20'hFFFFF;
         else
            to_quarters = {9'h000, v[10:0]} << (e + 5'h02);
      end
   endfunction

   // Below 87.5% of target: 8*sample < 7*target
   function low_vout;
      input [15:0] s;
      input [15:0] t;
      begin
         low_vout = ({s, 3'h0}) < ({3'h0, t} * 19'd7);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   reg  [7:0]  action_q;
   reg  [15:0] off_wait_q;
   reg  [15:0] off_ramp_q;
   reg         busy_q;
   reg         invalid_q;
   reg  [15:0] last_vout_q;
   reg  [3:0]  state_q;
   reg  [3:0]  state_d;
   reg  [2:0]  retries_q;
   reg  [2:0]  retries_d;
   reg  [31:0] cnt_q;
   reg  [31:0] cnt_d;
   reg         on_q;
   reg         fault_ev;
   reg         wr_bad;
   reg  [7:0]  summary;
   reg  [19:0] ramp_qms;

   wire [1:0]  act_code  = action_q[7:6];
   wire [2:0]  restart_n = action_q[5:3];
   wire [2:0]  wait_n    = action_q[2:0];
   wire        cnt_done  = (cnt_q == 32'h0);
   wire        wr        = cmd_valid && cmd_write;
   wire        wr_ok     = wr && !wr_bad;
   wire        wr_err    = wr && wr_bad;
   wire        off_cmd   = on_q && !on_request;
   wire        low_now   = low_vout(last_vout_q, target_output_voltage);
   // Zero wait field still gives one ramp time of restart period
   wire [31:0] hicc_cyc  = {29'h0, (wait_n == 3'h0) ? 3'h1 : wait_n} *
                           {25'h0, start_ramp_time} * QMS_CYC;
   wire [31:0] fwait_cyc = {29'h0, wait_n} * `TOL_QMS_PER_MS * QMS_CYC;
   wire [19:0] owait_qms = to_quarters(off_wait_q);
   // Loads one short: the ramp state also spends the edge at zero
   wire [31:0] ramp_cyc  = ramp_qms[6:0] * QMS_CYC - 32'h1;

   always @* begin
      ramp_qms = to_quarters(off_ramp_q);
      if (ramp_qms < `TOL_OFF_RAMP_MIN)
         ramp_qms = `TOL_OFF_RAMP_MIN;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Invalid write detection
   always @* begin
      wr_bad = 1'b0;
      case (cmd_code)
         `TOL_CMD_ACTION:
            wr_bad = (cmd_wdata[7:6] == 2'h3) || (cmd_wdata[15:8] != 8'h00);
         `TOL_CMD_OFF_WAIT:
            wr_bad = to_quarters(cmd_wdata) > `TOL_OFF_WAIT_MAX;
         `TOL_CMD_OFF_RAMP:
            wr_bad = to_quarters(cmd_wdata) > `TOL_OFF_RAMP_MAX;
         `TOL_CMD_SUMMARY:
            wr_bad = (cmd_wdata != {8'h00, `TOL_BUSY_CLEAR});
         default:
            wr_bad = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always @* begin
      state_d   = state_q;
      retries_d = retries_q;
      // Counter parks at zero between timed phases
      cnt_d     = cnt_done ? 32'h0 : cnt_q - 32'h1;
      fault_ev  = 1'b0;
      case (state_q)
         S_IDLE: begin
            // Fresh restart budget for the next turn-on
            retries_d = 3'h0;
            if (on_request && !on_q)
               state_d = S_START;
         end
         S_START: begin
            if (limit_expired) begin
               if (low_now) begin
                  fault_ev = 1'b1;
                  case (act_code)
                     `TOL_ACT_DELAYED: begin
                        state_d = S_FWAIT;
                        cnt_d   = fwait_cyc;
                     end
                     `TOL_ACT_NOW: begin
                        state_d = S_HICC;
                        cnt_d   = hicc_cyc;
                     end
                     default:
                        state_d = S_RUN;
                  endcase
               end else begin
                  state_d   = S_RUN;
                  retries_d = 3'h0;
               end
            end
         end
         S_FWAIT: begin
            if (cnt_done) begin
               if (low_now) begin
                  state_d = S_HICC;
                  cnt_d   = hicc_cyc;
               end else
                  state_d = S_RUN;
            end
         end
         S_HICC: begin
            // Shut down; a zero restart count latches at once, else decide on restart once the period runs out
            if (restart_n == 3'h0)
               state_d = S_LATCH;
            else if (cnt_done) begin
               if (restart_n == `TOL_RETRY_FOREVER)
                  state_d = S_START;
               else if (retries_q < restart_n) begin
                  state_d   = S_START;
                  retries_d = retries_q + 3'h1;
               end else
                  state_d = S_LATCH;
            end
         end
         S_OWAIT: begin
            if (cnt_done) begin
               state_d = S_ORAMP;
               cnt_d   = ramp_cyc;
            end
         end
         S_ORAMP: begin
            if (cnt_done)
               state_d = S_IDLE;
         end
         S_RUN, S_LATCH: begin
         end
         default:
            state_d = S_IDLE;
      endcase
      if (off_cmd) begin
         retries_d = 3'h0;
         if (state_q == S_START || state_q == S_RUN || state_q == S_FWAIT) begin
            state_d = S_OWAIT;
            cnt_d   = owait_qms[8:0] * QMS_CYC + INT_CYC;
         end else if (state_q != S_OWAIT && state_q != S_ORAMP)
            state_d = S_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Summary byte built from the detailed flags behind it
   always @* begin
      summary = {busy_q, !convert_en_q, output_overvoltage_fault_flag,
                 output_overcurrent_summary, input_undervoltage_summary,
                 temperature_summary, comm_memory_logic_summary | invalid_q,
                 turn_on_limit_flag_q};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stored settings, sticky flags and registered outputs
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         action_q             <= `TOL_NVM_ACTION;
         off_wait_q           <= `TOL_NVM_OFF_WAIT;
         off_ramp_q           <= `TOL_NVM_OFF_RAMP;
         busy_q               <= 1'b0;
         invalid_q            <= 1'b0;
         last_vout_q          <= 16'h0000;
         state_q              <= S_IDLE;
         retries_q            <= 3'h0;
         cnt_q                <= 32'h0;
         on_q                 <= 1'b0;
         cmd_ack_q            <= 1'b0;
         cmd_rdata_q          <= 16'h0000;
         convert_en_q         <= 1'b0;
         soft_off_ramp_q      <= 1'b0;
         turn_on_limit_flag_q <= 1'b0;
         vout_summary_q       <= 1'b0;
         smb_alert_n_q        <= 1'b1;
      end else begin
         on_q            <= on_request;
         state_q         <= state_d;
         retries_q       <= retries_d;
         cnt_q           <= cnt_d;
         cmd_ack_q       <= cmd_valid;
         convert_en_q    <= (state_d == S_START) || (state_d == S_RUN) ||
                            (state_d == S_FWAIT) || (state_d == S_OWAIT);
         soft_off_ramp_q <= (state_d == S_ORAMP);
         if (vout_valid)
            last_vout_q <= vout_sample;
         if (wr_ok) begin
            case (cmd_code)
               `TOL_CMD_ACTION:   action_q   <= cmd_wdata[7:0];
               `TOL_CMD_OFF_WAIT: off_wait_q <= cmd_wdata;
               `TOL_CMD_OFF_RAMP: off_ramp_q <= cmd_wdata;
               default: ;
            endcase
         end
         // Hardware set wins over any clear in the same cycle
         // Busy clears only on the exact 0080h word
         if (busy_event)
            busy_q <= 1'b1;
         else if (wr_ok && cmd_code == `TOL_CMD_SUMMARY)
            busy_q <= 1'b0;
         if (wr_err)
            invalid_q <= 1'b1;
         else if (clear_faults)
            invalid_q <= 1'b0;
         if (fault_ev)
            turn_on_limit_flag_q <= 1'b1;
         else if (clear_faults)
            turn_on_limit_flag_q <= 1'b0;
         vout_summary_q <= fault_ev || (turn_on_limit_flag_q && !clear_faults) ||
                           output_overvoltage_fault_flag;
         // Alert stays low until the flags behind it are cleared
         if (fault_ev || wr_err)
            smb_alert_n_q <= 1'b0;
         else if (clear_faults)
            smb_alert_n_q <= 1'b1;
         if (cmd_valid && !cmd_write) begin
            case (cmd_code)
               `TOL_CMD_ACTION:   cmd_rdata_q <= {8'h00, action_q};
               `TOL_CMD_OFF_WAIT: cmd_rdata_q <= off_wait_q;
               `TOL_CMD_OFF_RAMP: cmd_rdata_q <= off_ramp_q;
               `TOL_CMD_SUMMARY:  cmd_rdata_q <= {8'h00, summary};
               default:           cmd_rdata_q <= 16'h0000;
            endcase
         end
      end
   end

endmodule // tol_ctrl
`default_nettype wire

// file: hw/tol_map.vh
// Command codes, field positions, reset values and timing for the turn-on limit block
// What this block does
// - Turn-on limit fault sets the other-fault summary bit, any response code.
// - Fault also sets output-voltage summary and turn-on-limit flag in voltage flags.
// - Fault notifies the host by asserting the alert line.
// - Action field 7:6; 00 ignore, 01 run for shutdown wait then act if fault remains.
// - Action 10 shuts down at once, then restarts per the restart count field.
// - Restart count field 5:3; zero latches off after shutdown.
// - Count 1 to 6: wait one restart period, retry, at most that many times.
// - Count 7: retry forever until commanded off or start-up succeeds.
// - Wait field 2:0; zero gives no shutdown wait, period of one ramp time.
// - Wait N gives N ms shutdown wait and N ramp times of restart period.
// - Unlisted action byte, action 11 included, is invalid data: flag and alert.
// - Code 64h sets ms from stop request until energy delivery stops.
// - Off wait 0 to 127.5 ms in 0.25 ms steps, linear 5-bit exponent format.
// - Internal delay up to 50 us added to off wait, also when it is zero.
// - Off wait or ramp writes out of range are invalid data: flag and alert.
// - Code 65h sets ramp time from end of off wait until target reaches zero.
// - Ramp time exponent -2, 0.25 ms per step, exponent resets to 11110b.
// - Ramp covers 0.5 to 31.75 ms; shorter values run as 0.5 ms.
// - Summary byte at 78h follows the detailed flags behind each bit.
// - Summary layout: busy, off, OV, OC, input UV, temp, comm/logic, other.
// - Fault when last voltage sample before limit expiry is under 87.5% of target.
// - Writing 80h to the summary byte clears the busy bit.
`ifndef TOL_MAP_VH
`define TOL_MAP_VH
`define TOL_CMD_ACTION   8'h63
`define TOL_CMD_OFF_WAIT 8'h64
`define TOL_CMD_OFF_RAMP 8'h65
`define TOL_CMD_SUMMARY  8'h78
`define TOL_BUSY_CLEAR   8'h80
`define TOL_ACT_IGNORE   2'h0
`define TOL_ACT_DELAYED  2'h1
`define TOL_ACT_NOW      2'h2
`define TOL_RETRY_FOREVER 3'h7
`define TOL_NVM_ACTION   8'h80
`define TOL_NVM_OFF_WAIT 16'hF800
`define TOL_NVM_OFF_RAMP 16'hF004
`define TOL_EXP_MIN      5'h1E
`define TOL_OFF_WAIT_MAX 20'h001FE
`define TOL_OFF_RAMP_MAX 20'h0007F
`define TOL_OFF_RAMP_MIN 20'h00002
`define TOL_QMS_NS       250000
`define TOL_CLK_NS       20
`define TOL_INT_DLY_NS   50000
`define TOL_QMS_PER_MS   4
`endif

// file: verif/tol_ctrl_monitor.sv
// Property checker for the turn-on limit and soft-off block
`timescale 1ns/1ns
`default_nettype none
module tol_ctrl_monitor #(
   parameter [31:0] QMS_CYC = 4
) (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        cmd_valid,
   input wire logic        cmd_write,
   input wire logic [7:0]  cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic [15:0] cmd_rdata_q,
   input wire logic        on_request,
   input wire logic        limit_expired,
   input wire logic        clear_faults,
   input wire logic        output_overvoltage_fault_flag,
   input wire logic        convert_en_q,
   input wire logic        soft_off_ramp_q,
   input wire logic        turn_on_limit_flag_q,
   input wire logic        vout_summary_q,
   input wire logic        smb_alert_n_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic [15:0] ramp_cnt_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) ramp_cnt_q <= 16'h0000;
      else ramp_cnt_q <= soft_off_ramp_q ? ramp_cnt_q + 16'h0001 : 16'h0000;
   end
   sequence rd_sum;
      cmd_valid && !cmd_write && cmd_code == 8'h78;
   endsequence
   alert_on_fault_a:
      assert property ($rose(turn_on_limit_flag_q) |-> !smb_alert_n_q) else $error("no alert");
   vout_with_flag_a:
      assert property ($rose(turn_on_limit_flag_q) |-> vout_summary_q) else $error("no vout bit");
   summary_read_a:
      assert property (rd_sum |=> cmd_rdata_q[6:5] == {!$past(convert_en_q),
         $past(output_overvoltage_fault_flag)} && cmd_rdata_q[0] == $past(turn_on_limit_flag_q))
         else $error("summary byte wrong");
   flag_clear_a:
      assert property (clear_faults && !limit_expired && !cmd_valid |=>
         !turn_on_limit_flag_q && smb_alert_n_q) else $error("clear ignored");
   ramp_excl_a:
      assert property (soft_off_ramp_q |-> !convert_en_q) else $error("ramp while on");
   off_hold_a:
      assert property ($fell(on_request) && convert_en_q |=> convert_en_q [*8])
         else $error("off too early");
   // Lower bound only: the exact length follows the ramp register
   ramp_min_a:
      assert property ($fell(soft_off_ramp_q) |-> ramp_cnt_q >= 2 * QMS_CYC)
         else $error("ramp too short");
   bad_action_a:
      assert property (cmd_valid && cmd_write && cmd_code == 8'h63 && cmd_wdata[7:6] == 2'h3
         |=> !smb_alert_n_q) else $error("bad action no alert");
   bad_ramp_a:
      assert property (cmd_valid && cmd_write && cmd_code == 8'h65 && cmd_wdata[15:11] == 5'h1E
         && cmd_wdata[10:0] > 11'h07F |=> !smb_alert_n_q) else $error("bad ramp no alert");
endmodule // tol_ctrl_monitor
`default_nettype wire

// file: verif/tol_host.sv
// Command-port host model for register reads and writes
`timescale 1ns/1ns
`default_nettype none
module tol_host (
   input  wire logic        core_clk,
   output var  logic        cmd_valid,
   output var  logic        cmd_write,
   output var  logic [7:0]  cmd_code,
   output var  logic [15:0] cmd_wdata,
   input  wire logic        cmd_ack_q,
   input  wire logic [15:0] cmd_rdata_q
);
   initial cmd_valid = 1'b0;
   initial cmd_write = 1'b0;
   initial cmd_code = 8'h00;
   initial cmd_wdata = 16'h0000;
   // One-cycle strobe; busy clear is the 0080h word
   task xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [15:0] r);
      begin
         @(negedge core_clk);
         cmd_valid = 1'b1;
         cmd_write = w;
         cmd_code = c;
         cmd_wdata = d;
         @(negedge core_clk);
         cmd_valid = 1'b0;
         // Released lines invert so stale values never pass
         cmd_code = ~c;
         cmd_wdata = ~d;
         r = cmd_ack_q ? cmd_rdata_q : 16'hXXXX;
      end
   endtask
endmodule // tol_host
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the turn-on limit and soft-off block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic        core_clk = 1'b0, rst_n = 1'b0, on_request = 1'b0, limit_expired = 1'b0;
   logic        vout_valid = 1'b0, busy_event = 1'b0, clear_faults = 1'b0, ov_flag = 1'b0;
   logic [3:0]  flags_in = 4'h0;
   logic [15:0] vout_sample = 16'h0000, target = 16'h0800, rd_q;
   logic [6:0]  rise = 7'h02;
   wire         cmd_valid, cmd_write, cmd_ack_q, convert_en_q, soft_off_ramp_q;
   wire         flag_q, vsum_q, alert_n_q;
   wire  [7:0]  cmd_code;
   wire  [15:0] cmd_wdata, cmd_rdata_q;
   integer      failures = 0, n_tests = 0, n, k;
   always #10 core_clk = ~core_clk;
   tol_host u_host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ack_q(cmd_ack_q), .cmd_rdata_q(cmd_rdata_q));
   tol_ctrl #(.QMS_CYC(32'h4)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ack_q(cmd_ack_q),
      .cmd_rdata_q(cmd_rdata_q), .on_request(on_request), .limit_expired(limit_expired),
      .vout_valid(vout_valid), .vout_sample(vout_sample), .target_output_voltage(target),
      .start_ramp_time(rise), .busy_event(busy_event), .clear_faults(clear_faults),
      .output_overvoltage_fault_flag(ov_flag), .output_overcurrent_summary(flags_in[3]),
      .input_undervoltage_summary(flags_in[2]), .temperature_summary(flags_in[1]),
      .comm_memory_logic_summary(flags_in[0]), .convert_en_q(convert_en_q),
      .soft_off_ramp_q(soft_off_ramp_q), .turn_on_limit_flag_q(flag_q),
      .vout_summary_q(vsum_q), .smb_alert_n_q(alert_n_q));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task summarize;
      begin
         $display("Comparisons %0d, mismatches %0d", n_tests, failures);
         if (failures == 0 && n_tests > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   task wr(input logic [7:0] c, input logic [15:0] d);
      u_host.xfer(1'b1, c, d, rd_q);
   endtask
   task rd(input logic [7:0] c, input logic [15:0] e);
      begin
         u_host.xfer(1'b0, c, 16'h0000, rd_q);
         chk(rd_q, e);
      end
   endtask
   task wait_en(input logic v, input integer lim);
      begin
         for (n = 0; n < lim && convert_en_q !== v; n = n + 1) @(negedge core_clk);
         if (convert_en_q !== v) begin
            failures = failures + 1;
            summarize;
         end
      end
   endtask
   task pulse_fault(input logic [15:0] s);
      begin
         vout_sample = s;
         vout_valid = 1'b1;
         @(negedge core_clk);
         vout_valid = 1'b0;
         limit_expired = 1'b1;
         @(negedge core_clk);
         limit_expired = 1'b0;
         vout_sample = ~s;
      end
   endtask
   task try_start(input logic [15:0] s);
      begin
         @(negedge core_clk);
         on_request = 1'b1;
         wait_en(1'b1, 8);
         pulse_fault(s);
      end
   endtask
   task idle;
      begin
         on_request = 1'b0;
         clear_faults = 1'b1;
         @(negedge core_clk);
         clear_faults = 1'b0;
      end
   endtask
   task t_regs;
      begin
         rd(8'h63, 16'h0080);
         rd(8'h64, 16'hF800);
         rd(8'h65, 16'hF004);
         wr(8'h65, 16'hF080);
         rd(8'h65, 16'hF004);
         chk(alert_n_q, 0);
         idle;
         wr(8'h63, 16'h00C0);
         rd(8'h78, 16'h0042);
         rd(8'h63, 16'h0080);
         idle;
         wr(8'h64, 16'hF1FE);
         rd(8'h64, 16'hF1FE);
         busy_event = 1'b1;
         @(negedge core_clk);
         busy_event = 1'b0;
         ov_flag = 1'b1;
         flags_in = 4'hF;
         rd(8'h78, 16'h00FE);
         wr(8'h78, 16'h0080);
         ov_flag = 1'b0;
         flags_in = 4'h0;
         rd(8'h78, 16'h0040);
         $display("t_regs finished");
      end
   endtask
   task t_soft;
      begin
         wr(8'h64, 16'hF004);
         wr(8'h65, 16'hF001);
         try_start(16'h0700);
         chk(flag_q, 0);
         on_request = 1'b0;
         wait_en(1'b0, 3000);
         chk(n >= 2516 && n <= 2519, 1);
         for (k = 0; k < 3 && !soft_off_ramp_q; k = k + 1) @(negedge core_clk);
         for (k = 0; k < 40 && soft_off_ramp_q; k = k + 1) @(negedge core_clk);
         chk(k, 8);
         $display("t_soft finished");
      end
   endtask
   task t_latch;
      begin
         try_start(16'h06FF);
         chk({flag_q, convert_en_q, alert_n_q, vsum_q}, 4'h9);
         rd(8'h78, 16'h0041);
         repeat (20) @(negedge core_clk);
         chk(convert_en_q, 0);
         idle;
         rd(8'h78, 16'h0040);
         $display("t_latch finished");
      end
   endtask
   task t_retry;
      begin
         wr(8'h63, 16'h0088);
         try_start(16'h06FF);
         chk(convert_en_q, 0);
         wait_en(1'b1, 20);
         chk(n >= 7 && n <= 12, 1);
         pulse_fault(16'h0600);
         repeat (30) @(negedge core_clk);
         chk(convert_en_q, 0);
         idle;
         wr(8'h63, 16'h00B8);
         try_start(16'h06FF);
         for (k = 0; k < 8; k = k + 1) begin
            wait_en(1'b1, 20);
            chk(convert_en_q, 1);
            pulse_fault(16'h06FF);
         end
         idle;
         $display("t_retry finished");
      end
   endtask
   task t_delay;
      begin
         wr(8'h63, 16'h0041);
         try_start(16'h06FF);
         chk(convert_en_q, 1);
         wait_en(1'b0, 40);
         chk(n >= 14 && n <= 18, 1);
         idle;
         wr(8'h63, 16'h0000);
         try_start(16'h0600);
         repeat (30) @(negedge core_clk);
         chk({convert_en_q, flag_q}, 2'h3);
         on_request = 1'b0;
         wait_en(1'b0, 3000);
         repeat (20) @(negedge core_clk);
         idle;
         $display("t_delay finished");
      end
   endtask
   initial begin
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      t_regs;
      t_soft;
      t_latch;
      t_retry;
      t_delay;
      summarize;
   end
endmodule // testbench
bind tol_ctrl tol_ctrl_monitor #(.QMS_CYC(QMS_CYC)) u_mon (.core_clk(core_clk), .rst_n(rst_n),
   .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
   .cmd_rdata_q(cmd_rdata_q), .on_request(on_request), .limit_expired(limit_expired),
   .clear_faults(clear_faults), .output_overvoltage_fault_flag(output_overvoltage_fault_flag),
   .convert_en_q(convert_en_q), .soft_off_ramp_q(soft_off_ramp_q),
   .turn_on_limit_flag_q(turn_on_limit_flag_q), .vout_summary_q(vout_summary_q),
   .smb_alert_n_q(smb_alert_n_q));
`default_nettype wire
